// ---- rtl/parallel_port_addr_status.sv ----
// Purpose: Address, pad enable and buffer status of a parallel port
// Assumes: Host pins are asynchronous; all sampled through two flops
// Notes:   Host access counted on rising edge of the synchronised strobe
`timescale 1ns/1ps
module parallel_port_addr_status #(
  parameter bit SMALL_PKG = 1'b0 // Package without address pads 10..2
) (
  input  wire logic              sys_clk,       // 40 MHz clock
  input  wire logic              rst_n,         // Sync reset, active low
  input  wire logic              wb_cyc_i,      // Wishbone cycle
  input  wire logic              wb_stb_i,      // Wishbone strobe
  input  wire logic              wb_we_i,       // Wishbone write
  input  wire logic [3:0]        wb_sel_i,      // Wishbone byte select
  input  wire logic [5:0]        wb_adr_i,      // Wishbone byte address
  input  wire logic [31:0]       wb_dat_i,      // Wishbone write data
  output logic      [31:0]       wb_dat_o,      // Wishbone read data
  output logic                   wb_ack_o,      // Wishbone ack
  input  wire logic              hostStrobe,    // Host access strobe pin
  input  wire logic              hostWrite,     // Host direction pin
  input  wire logic [1:0]        hostSel,       // Host buffer select pins
  input  wire logic [7:0]        hostData,      // Host data pins
  output logic      [7:0]        hostDataOut,   // Data to host
  output logic      [15:0]       addrOut,       // Port address value
  output logic                   chipSelect,    // Chip select one level
  output logic      [15:0]       padOwned,      // Pads owned by port
  output logic                   inputThreshold,// Input threshold select
  output logic                   clockPinSource,// Clock pin source select
  output logic      [1:0]        portMode,      // Port mode field
  output logic                   irq            // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block, all but the pad ownership register padReg
  typedef struct packed {
    logic [15:0]        ctrl;     // Mode, irq mode, step mode
    logic [15:0]        addr;     // port_target_address
    logic [15:0]        paden;    // port_pad_enable
    logic [15:0]        padcfg;   // pad_input_config
    logic               input_overflow_flag;     // Input overflow sticky
    logic               output_underflow_flag;     // Output underflow sticky
    logic [3:0]         ifull;    // Per-buffer input full
    logic [3:0]         oempty;   // Per-buffer output empty
    logic [3:0][7:0]    ibuf;     // Input bytes
    logic [3:0][7:0]    obuf8;    // Output bytes
    logic [4:0]         evt;      // Sticky interrupt status
    logic [4:0]         evtEn;    // Interrupt enable
    pport_pkg::host_in_s s1;      // First sync stage
    pport_pkg::host_in_s s2;      // Second sync stage
    logic               strbOld;  // Last strobe for edge detect
    logic [7:0]         hOut;     // Data to host
    logic [31:0]        rdat;     // Bus read data
    logic               ack;      // Bus ack
    logic               irqOut;   // Interrupt output
  } state_s;

  state_s stReg;  // Registered state
  state_s stNext; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  always_comb
  begin
    logic        busHit;
    logic        wr;
    logic        rd;
    logic [15:0] wv;
    logic [15:0] rv;
    logic        hAcc;
    logic [1:0]  bsel;
    logic [1:0]  mode;
    logic [3:0]  rdIb;
    logic [3:0]  wrOb;
    logic [4:0]  evNow;
    busHit  = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    wv      = 16'h0000;
    rv      = 16'h0000;
    hAcc    = 1'b0;
    bsel    = 2'h0;
    mode    = 2'h0;
    rdIb    = 4'h0;
    wrOb    = 4'h0;
    evNow   = 5'h00;
    stNext  = stReg;

    // Host pins through two flops; only stage two is read
    stNext.s1      = {hostStrobe, hostWrite, hostSel, hostData};
    stNext.s2      = stReg.s1;
    stNext.strbOld = stReg.s2.strobe;
    hAcc = stReg.s2.strobe && !stReg.strbOld;
    mode = stReg.ctrl[1:0];

    // Bus access: one wait state, ack pulses a single cycle
    busHit = wb_cyc_i && wb_stb_i && !stReg.ack;
    wr     = busHit && wb_we_i;
    rd     = busHit && !wb_we_i;
    wv     = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
              wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00};
    stNext.ack = busHit;

    // Buffer select: address lines in addressed mode, else step order
    if (mode == pport_pkg::MODE_ENH)
    begin
      bsel = stReg.s2.sel;
    end
    else
    begin
      bsel = stReg.addr[1:0];
    end

    // Host side of the buffers (slave modes only)
    if (hAcc && !mode[1])
    begin
      if (stReg.s2.write)
      begin
        if (stReg.ifull[bsel])
        begin
          stNext.input_overflow_flag = 1'b1;
          evNow[pport_pkg::EV_OVF] = 1'b1;
        end
        else
        begin
          stNext.ibuf[bsel]  = stReg.s2.data;
          stNext.ifull[bsel] = 1'b1;
        end
      end
      else
      begin
        if (stReg.oempty[bsel])
        begin
          stNext.output_underflow_flag = 1'b1;
          evNow[pport_pkg::EV_UNF] = 1'b1;
        end
        else
        begin
          stNext.oempty[bsel] = 1'b1;
        end
        stNext.hOut = stReg.obuf8[bsel];
      end
      // Interrupt request according to irq mode
      if (stReg.ctrl[3:2] == pport_pkg::IRQ_CYCLE)
      begin
        evNow[pport_pkg::EV_IRQ] = 1'b1;
      end
      else if (stReg.ctrl[3:2] == pport_pkg::IRQ_BUF3 &&
               bsel == pport_pkg::LAST_BUF)
      begin
        evNow[pport_pkg::EV_IRQ] = 1'b1;
      end
      // Address stepping after each cycle, eleven bits wide
      if (stReg.ctrl[5:4] == pport_pkg::STEP_INC)
      begin
        stNext.addr = (stReg.addr & ~pport_pkg::STEP_MSK) |
          ((stReg.addr + 16'h0001) & pport_pkg::STEP_MSK);
      end
      else if (stReg.ctrl[5:4] == pport_pkg::STEP_DEC)
      begin
        stNext.addr = (stReg.addr & ~pport_pkg::STEP_MSK) |
          ((stReg.addr - 16'h0001) & pport_pkg::STEP_MSK);
      end
    end

    // Software buffer side
    for (int i = 0; i < pport_pkg::NBUF; i++)
    begin
      rdIb[i] = rd && wb_adr_i == pport_pkg::OFF_IBUF + 6'(4 * i);
      wrOb[i] = wr && wb_adr_i == pport_pkg::OFF_OUTPUT_UNDERFLOW_FLAG + 6'(4 * i);
      // A host fill landing in the same cycle beats the read clear,
      // otherwise the fresh byte would be lost unseen
      if (rdIb[i] && !(stNext.ifull[i] && !stReg.ifull[i]))
      begin
        stNext.ifull[i] = 1'b0;
      end
      if (wrOb[i] && wb_sel_i[0])
      begin
        stNext.obuf8[i]  = wb_dat_i[7:0];
        stNext.oempty[i] = 1'b0;
      end
    end

    // Register writes; unimplemented bits masked off
    if (wr)
    begin
      case (wb_adr_i)
        pport_pkg::OFF_CTRL:   stNext.ctrl   = wv & pport_pkg::CTRL_MSK;
        pport_pkg::OFF_ADDR:   stNext.addr   = wv;
        pport_pkg::OFF_PADEN:  stNext.paden  = wv & pport_pkg::PADEN_MSK;
        pport_pkg::OFF_PADCFG: stNext.padcfg = wv & pport_pkg::PADCFG_MSK;
        pport_pkg::OFF_STAT:
        begin
          // Software may only clear the sticky flags; hardware set wins
          if (!wv[pport_pkg::STAT_INPUT_OVERFLOW_FLAG] && !evNow[pport_pkg::EV_OVF])
          begin
            stNext.input_overflow_flag = 1'b0;
          end
          if (!wv[pport_pkg::STAT_OUTPUT_UNDERFLOW_FLAG] && !evNow[pport_pkg::EV_UNF])
          begin
            stNext.output_underflow_flag = 1'b0;
          end
        end
        pport_pkg::OFF_IRQCLR: stNext.evt  = stReg.evt & ~wv[4:0];
        pport_pkg::OFF_IRQEN:  stNext.evtEn = wv[4:0];
        default: ;
      endcase
    end

    // Aggregate events, set beats clear
    evNow[pport_pkg::EV_FUL] = &stNext.ifull && !(&stReg.ifull);
    evNow[pport_pkg::EV_EMP] = &stNext.oempty && !(&stReg.oempty);
    stNext.evt    = stNext.evt | evNow;
    stNext.irqOut = |(stNext.evt & stNext.evtEn);

    // Register reads; unmapped addresses read zero
    case (wb_adr_i)
      pport_pkg::OFF_CTRL:    rv = stReg.ctrl;
      pport_pkg::OFF_ADDR:    rv = stReg.addr;
      pport_pkg::OFF_PADEN:   rv = stReg.paden;
      pport_pkg::OFF_PADCFG:  rv = stReg.padcfg;
      pport_pkg::OFF_STAT:
      begin
        rv[pport_pkg::STAT_IBF]  = &stReg.ifull;
        rv[pport_pkg::STAT_INPUT_OVERFLOW_FLAG] = stReg.input_overflow_flag;
        rv[pport_pkg::STAT_IBF0 +: 4] = stReg.ifull;
        rv[pport_pkg::STAT_OBE]  = &stReg.oempty;
        rv[pport_pkg::STAT_OUTPUT_UNDERFLOW_FLAG] = stReg.output_underflow_flag;
        rv[pport_pkg::STAT_OBE0 +: 4] = stReg.oempty;
      end
      pport_pkg::OFF_IRQSTAT: rv = {11'h000, stReg.evt};
      pport_pkg::OFF_IRQEN:   rv = {11'h000, stReg.evtEn};
      default:
      begin
        for (int i = 0; i < pport_pkg::NBUF; i++)
        begin
          if (wb_adr_i == pport_pkg::OFF_IBUF + 6'(4 * i))
          begin
            rv = {8'h00, stReg.ibuf[i]};
          end
          if (wb_adr_i == pport_pkg::OFF_OUTPUT_UNDERFLOW_FLAG + 6'(4 * i))
          begin
            rv = {8'h00, stReg.obuf8[i]};
          end
        end
      end
    endcase
    stNext.rdat = rd ? {16'h0000, rv} : 32'h0000_0000;

    // Reset values
    if (!rst_n)
    begin
      stNext        = '0;
      stNext.oempty = pport_pkg::STAT_RESET[pport_pkg::STAT_OBE0 +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    stReg <= stNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad ownership register, outputs straight from flops
  logic [15:0] padReg;  // Owned pads
  logic [15:0] padNext; // Next owned pads
  // Small package: no pads 10..2 exist, so their enables own nothing
  always_comb
  begin
    padNext = (SMALL_PKG ? ~pport_pkg::PADEN_MID : 16'hFFFF) & stNext.paden;
  end
  always_ff @(posedge sys_clk)
  begin
    padReg <= padNext;
  end

  assign wb_dat_o       = stReg.rdat;
  assign wb_ack_o       = stReg.ack;
  assign hostDataOut    = stReg.hOut;
  assign addrOut        = stReg.addr;
  assign chipSelect     = stReg.addr[pport_pkg::ADDR_CS_BIT];
  assign padOwned       = padReg;
  assign inputThreshold = stReg.padcfg[0];
  assign clockPinSource = stReg.padcfg[1];
  assign portMode       = stReg.ctrl[1:0];
  assign irq            = stReg.irqOut;

endmodule

// ---- rtl/pport_pkg.sv ----
// Purpose: Constants and types for the parallel port address/status block
// Assumes: Classic Wishbone, 32-bit data, registers in low 16 bits
// Notes:   Register offsets are byte addresses
package pport_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [5:0] OFF_CTRL    = 6'h00; // Mode, irq, step fields
  localparam logic [5:0] OFF_ADDR    = 6'h04; // port_target_address
  localparam logic [5:0] OFF_PADEN   = 6'h08; // port_pad_enable
  localparam logic [5:0] OFF_STAT    = 6'h0C; // port_buffer_status
  localparam logic [5:0] OFF_PADCFG  = 6'h10; // pad_input_config
  localparam logic [5:0] OFF_IRQSTAT = 6'h14; // Sticky event status
  localparam logic [5:0] OFF_IRQCLR  = 6'h18; // Write one to clear
  localparam logic [5:0] OFF_IRQEN   = 6'h1C; // Event enable
  localparam logic [5:0] OFF_IBUF    = 6'h20; // Input buffers 0..3
  localparam logic [5:0] OFF_OUTPUT_UNDERFLOW_FLAG    = 6'h30; // Output buffers 0..3

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and masks
  localparam int          ADDR_TOP_BIT = 15;
  localparam int          ADDR_CS_BIT  = 14;
  localparam logic [15:0] ADDR_LOW_MSK = 16'h3FFF;
  localparam logic [15:0] PADEN_MSK    = 16'h47FF;
  localparam logic [15:0] PADEN_MID    = 16'h07FC; // Pads 10..2
  localparam logic [15:0] PADCFG_MSK   = 16'h0003;
  localparam logic [15:0] CTRL_MSK     = 16'h007F;
  localparam logic [15:0] STEP_MSK     = 16'h07FF; // Eleven-bit stepping
  localparam int          PAD14_BIT    = 14;
  localparam int          STAT_IBF     = 15;
  localparam int          STAT_INPUT_OVERFLOW_FLAG    = 14;
  localparam int          STAT_IBF0    = 8;
  localparam int          STAT_OBE     = 7;
  localparam int          STAT_OUTPUT_UNDERFLOW_FLAG    = 6;
  localparam int          STAT_OBE0    = 0;
  localparam int          NBUF         = 4;
  localparam int          NEVT         = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] MODE_LEGACY  = 2'h0;
  localparam logic [1:0] MODE_ENH     = 2'h1;
  localparam logic [1:0] MODE_MASTER2 = 2'h2;
  localparam logic [1:0] MODE_MASTER1 = 2'h3;
  localparam logic [1:0] IRQ_NONE     = 2'h0;
  localparam logic [1:0] IRQ_CYCLE    = 2'h1;
  localparam logic [1:0] IRQ_BUF3     = 2'h3;
  localparam logic [1:0] STEP_INC     = 2'h1;
  localparam logic [1:0] STEP_DEC     = 2'h2;
  localparam logic [1:0] LAST_BUF     = 2'h3;
  // Event bits: 0 overflow, 1 underflow, 2 all-full, 3 all-empty, 4 port irq
  localparam int EV_OVF = 0;
  localparam int EV_UNF = 1;
  localparam int EV_FUL = 2;
  localparam int EV_EMP = 3;
  localparam int EV_IRQ = 4;
  localparam logic [15:0] STAT_RESET = 16'h008F;

  ////////////////////////////////////////////////////////////////////////////
  // Bundles
  typedef struct packed {
    logic       cyc;   // Cycle
    logic       stb;   // Strobe
    logic       we;    // Write
    logic [3:0] sel;   // Byte lanes
    logic [5:0] adr;   // Byte address
    logic [31:0] dat;  // Write data
  } wb_req_s;

  typedef struct packed {
    logic       strobe; // Synchronised access strobe (pre-edge)
    logic       write;  // Synchronised direction, 1 = host writes
    logic [1:0] sel;    // Synchronised buffer select
    logic [7:0] data;   // Synchronised host data
  } host_in_s;

endpackage

// ---- dv/pport_asserts.sv ----
// Purpose: Port-level checks of the parallel port address/status block
// Assumes: Bus master waits for ack; byte lanes 0 and 1 always on
// Notes:   Sees only top ports; bound from the bench top file
`timescale 1ns/1ps
module pport_asserts #(
  parameter bit SMALL_PKG = 1'b0 // Package without pads 10..2
) (
  input wire logic        sys_clk,        // Clock
  input wire logic        rst_n,          // Sync reset
  input wire logic        wb_cyc_i,       // Cycle
  input wire logic        wb_stb_i,       // Strobe
  input wire logic        wb_we_i,        // Write
  input wire logic [3:0]  wb_sel_i,       // Lanes
  input wire logic [5:0]  wb_adr_i,       // Address
  input wire logic [31:0] wb_dat_i,       // Write data
  input wire logic [31:0] wb_dat_o,       // Read data
  input wire logic        wb_ack_o,       // Ack
  input wire logic [15:0] addrOut,        // Port address
  input wire logic        chipSelect,     // Chip select
  input wire logic [15:0] padOwned,       // Pads owned
  input wire logic [1:0]  portMode        // Mode field
);
  // Small package loses the middle pads, so their enables drive nothing
  localparam logic [15:0] PAD_MASK = SMALL_PKG ?
    (pport_pkg::PADEN_MSK & ~pport_pkg::PADEN_MID) : pport_pkg::PADEN_MSK;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////
  // Request taken, then narrowed to a write or a status read
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wrTo(logic [5:0] a);
    taken ##0 (wb_we_i && wb_adr_i == a && (&wb_sel_i[1:0]));
  endsequence
  sequence rdStat;
    taken ##0 (!wb_we_i && wb_adr_i == pport_pkg::OFF_STAT);
  endsequence

  a_ack_pulse:
    assert property (taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer is not a one-cycle pulse");
  a_addr_store:
    assert property (wrTo(pport_pkg::OFF_ADDR) |=>
      addrOut == $past(wb_dat_i[15:0]))
    else $error("Port address not taken from write");
  a_cs_follow:
    assert property (chipSelect == addrOut[pport_pkg::ADDR_CS_BIT])
    else $error("Chip select differs from address bit 14");
  a_pad_store:
    assert property (wrTo(pport_pkg::OFF_PADEN) |=> ##1
      padOwned == ($past(wb_dat_i[15:0], 2) & PAD_MASK))
    else $error("Pad ownership does not follow enables");
  a_pad_absent:
    assert property ((padOwned & ~PAD_MASK) == 16'h0000)
    else $error("Pad owned where no pad exists");
  a_stat_zero:
    assert property (rdStat |=> (wb_dat_o & 32'hFFFF_3030) == 32'h0)
    else $error("Unimplemented status bits not zero");
  a_full_summary:
    assert property (rdStat |=> wb_dat_o[15] == (&wb_dat_o[11:8]))
    else $error("All-full bit disagrees with buffer flags");
  a_empty_summary:
    assert property (rdStat |=> wb_dat_o[7] == (&wb_dat_o[3:0]))
    else $error("All-empty bit disagrees with buffer flags");
  a_mode_store:
    assert property (wrTo(pport_pkg::OFF_CTRL) |=>
      portMode == $past(wb_dat_i[1:0]))
    else $error("Mode output not taken from write");
endmodule

// ---- dv/pport_host_model.sv ----
// Purpose: External host that reads and writes the port byte buffers
// Assumes: Strobe held 4 clocks each level, above the 3-clock minimum
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module pport_host_model (
  input  wire logic       sys_clk,    // Paces the host
  output logic            hostStrobe, // Access strobe
  output logic            hostWrite,  // 1 = host writes
  output logic      [1:0] hostSel,    // Buffer select
  output logic      [7:0] hostData    // Host data
);
  // Idle pins at time zero
  initial
  begin
    hostStrobe = 1'b0;
    hostWrite  = 1'b0;
    hostSel    = 2'h0;
    hostData   = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // One host cycle; select and data set up a clock before the strobe
  task xfer(input logic w, input logic [1:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    hostWrite <= w;
    hostSel   <= s;
    hostData  <= d;
    @(posedge sys_clk);
    hostStrobe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    hostStrobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Stale data would hide a late sample, so show its inverse
    hostData <= ~d;
  endtask
endmodule

// ---- dv/parallel_port_addr_status_tb.sv ----
// Purpose: Self-checking bench of the parallel port address/status block
// Assumes: Classic single Wishbone cycles, host model on the far side
// Notes:   Scenarios run in order and share buffer state
`timescale 1ns/1ps
bind parallel_port_addr_status pport_asserts #(.SMALL_PKG(SMALL_PKG)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .addrOut(addrOut), .chipSelect(chipSelect),
  .padOwned(padOwned), .portMode(portMode));
module parallel_port_addr_status_tb;
  logic        sys_clk, rst_n, cyc, stb, we, ack; // Clock and bus
  logic [5:0]  adr;                               // Bus address
  logic [31:0] wdat, rdat;                        // Bus data
  logic [15:0] rd, addrOut, padOwned;             // Read value, outputs
  logic [7:0]  hostDataOut, hostData;             // Host data
  logic [1:0]  portMode, hostSel;                 // Mode, select
  logic        chipSelect, inputThreshold, clockPinSource, irq;
  logic        hostStrobe, hostWrite;             // Host controls
  int          n_fail = 0, n_tests = 0, cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  parallel_port_addr_status i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hostStrobe(hostStrobe), .hostWrite(hostWrite), .hostSel(hostSel),
    .hostData(hostData), .hostDataOut(hostDataOut), .addrOut(addrOut),
    .chipSelect(chipSelect), .padOwned(padOwned),
    .inputThreshold(inputThreshold), .clockPinSource(clockPinSource),
    .portMode(portMode), .irq(irq));
  pport_host_model i_host (.sys_clk(sys_clk), .hostStrobe(hostStrobe),
    .hostWrite(hostWrite), .hostSel(hostSel), .hostData(hostData));

  //////////////////////////////////////////////////////////////////////////
  // Compare, bus cycle, settle
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Holds the request until ack is seen, then releases it
  task wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 16'h0000, d};
    // Ack and read data are taken at the edge that samples ack high
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 16);
    rd = rdat[15:0];
    chk({15'h0000, ack}, 16'h0001);
    {cyc, stb} <= 2'b00;
  endtask
  task rdc(input logic [5:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(rd, e);
  endtask
  task settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs();
    rdc(pport_pkg::OFF_STAT, 16'h008F);
    wb(1'b1, pport_pkg::OFF_ADDR, 16'hC123);
    chk(addrOut, 16'hC123);
    chk({15'h0000, chipSelect}, 16'h0001);
    wb(1'b1, pport_pkg::OFF_ADDR, 16'h3FFF);
    rdc(pport_pkg::OFF_ADDR, 16'h3FFF);
    chk({15'h0000, chipSelect}, 16'h0000);
    wb(1'b1, pport_pkg::OFF_PADEN, 16'hFFFF);
    rdc(pport_pkg::OFF_PADEN, 16'h47FF);
    chk(padOwned, 16'h47FF);
    wb(1'b1, pport_pkg::OFF_PADCFG, 16'hFFFF);
    rdc(pport_pkg::OFF_PADCFG, 16'h0003);
    chk({14'h0000, clockPinSource, inputThreshold}, 16'h0003);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, pport_pkg::OFF_CTRL, {14'h0000, m[1:0]});
      chk({14'h0000, portMode}, {14'h0000, m[1:0]});
    end
  endtask
  // Overfill the inputs in addressed mode, then drain them
  task t_inbuf();
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h0001);
    for (int i = 0; i < 4; i++) i_host.xfer(1'b1, i[1:0], 8'hA0 + i[7:0]);
    rdc(pport_pkg::OFF_STAT, 16'h8F8F);
    i_host.xfer(1'b1, 2'h0, 8'hEE);
    rdc(pport_pkg::OFF_STAT, 16'hCF8F);
    for (int i = 0; i < 4; i++)
      rdc({2'h2, i[1:0], 2'h0}, 16'h00A0 + i[15:0]);
    rdc(pport_pkg::OFF_STAT, 16'h408F);
    wb(1'b1, pport_pkg::OFF_STAT, 16'h0000);
    rdc(pport_pkg::OFF_STAT, 16'h008F);
  endtask
  // Fill the outputs, let the host take them, then read one too many
  task t_outbuf();
    for (int i = 0; i < 4; i++)
      wb(1'b1, {2'h3, i[1:0], 2'h0}, 16'h0050 + i[15:0]);
    rdc(pport_pkg::OFF_STAT, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      i_host.xfer(1'b0, i[1:0], 8'h00);
      chk({8'h00, hostDataOut}, 16'h0050 + i[15:0]);
    end
    rdc(pport_pkg::OFF_STAT, 16'h008F);
    i_host.xfer(1'b0, 2'h2, 8'h00);
    rdc(pport_pkg::OFF_STAT, 16'h00CF);
    wb(1'b1, pport_pkg::OFF_STAT, 16'h0000);
    rdc(pport_pkg::OFF_STAT, 16'h008F);
  endtask
  // Address steps wrap within eleven bits; master mode 2 ignores the host
  task t_step();
    wb(1'b1, pport_pkg::OFF_ADDR, 16'h47FF);
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h0011);
    i_host.xfer(1'b1, 2'h1, 8'h11);
    chk(addrOut, 16'h4000);
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h0021);
    i_host.xfer(1'b1, 2'h2, 8'h22);
    chk(addrOut, 16'h47FF);
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h0022);
    i_host.xfer(1'b1, 2'h3, 8'h33);
    chk(addrOut, 16'h47FF);
  endtask
  // Buffer-three interrupt: raise, mask, unmask, clear
  task t_irq();
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h000D);
    wb(1'b1, pport_pkg::OFF_IRQCLR, 16'h001F);
    wb(1'b1, pport_pkg::OFF_IRQEN, 16'h0010);
    i_host.xfer(1'b1, 2'h0, 8'h44);
    chk({15'h0000, irq}, 16'h0000);
    i_host.xfer(1'b1, 2'h3, 8'h55);
    chk({15'h0000, irq}, 16'h0001);
    rdc(pport_pkg::OFF_IRQSTAT, 16'h0014);
    wb(1'b1, pport_pkg::OFF_IRQEN, 16'h0000);
    settle();
    chk({15'h0000, irq}, 16'h0000);
    wb(1'b1, pport_pkg::OFF_IRQEN, 16'h0010);
    settle();
    chk({15'h0000, irq}, 16'h0001);
    wb(1'b1, pport_pkg::OFF_IRQCLR, 16'h0010);
    settle();
    chk({15'h0000, irq}, 16'h0000);
    // Irq mode 01: any host cycle fires; buffer one is full, so it overflows
    wb(1'b1, pport_pkg::OFF_CTRL, 16'h0005);
    wb(1'b1, pport_pkg::OFF_IRQCLR, 16'h001F);
    i_host.xfer(1'b1, 2'h1, 8'h66);
    chk({15'h0000, irq}, 16'h0001);
    rdc(pport_pkg::OFF_IRQSTAT, 16'h0011);
  endtask

  task close_out();
    $display("Compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under 2000 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    {sys_clk, rst_n, cyc, stb, we, adr, wdat} = 43'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_inbuf();
    t_outbuf();
    t_step();
    t_irq();
    close_out();
  end
endmodule
